/* verilog/pmusq_defines.svh */
`ifndef PMUSQ_DEFINES_SVH
`define PMUSQ_DEFINES_SVH
// Overview of operation
// - backup present, main absent or low: keep-alive regulator runs from backup battery.
// - main battery available: keep-alive runs from main, backup charging enabled.
// - charge current code 0/1/2 selects 375/500/625 uA.
// - fault threshold and charge current come from software-writable settings.
// - high-voltage rail request enables the high-voltage supply group.
// - low-voltage rail request enables the low-voltage regulator group.
// - supply monitoring drives active-low battery fault and supply fault outputs.
// - both fault outputs stay low while main input is below threshold.
// - first backup connection turns keep-alive on and asserts power-on reset.
// - reset output released no earlier than 50 ms after keep-alive valid.
// - battery fault released once main power present; processor waits for it.
// - supply fault released within 120 ms of low-voltage request when rails regulate.
// - reset input low asserts reset output, held at least 50 ms.
// - three-bit threshold code decodes to hysteresis pair, 2.4/2.6 V at code 0.

`define PMUSQ_ADDR_W        8
`define PMUSQ_ADDR_CTRL     8'h00
`define PMUSQ_ADDR_STATUS   8'h04
`define PMUSQ_ADDR_IRQ_STAT 8'h08
`define PMUSQ_ADDR_IRQ_MASK 8'h0C

`define PMUSQ_CTRL_CHG_RNG  1:0
`define PMUSQ_CTRL_THR_RNG  4:2
`define PMUSQ_CTRL_CHGOFF   5
`define PMUSQ_CHG_RST       2'h1
`define PMUSQ_THR_RST       3'h2

`define PMUSQ_CHG_UA0       10'h177
`define PMUSQ_CHG_UA1       10'h1F4
`define PMUSQ_CHG_UA2       10'h271
`define PMUSQ_CHG_UA_OFF    10'h000

`define PMUSQ_THR_REL_BASE  6'h18
`define PMUSQ_THR_ASR_BASE  6'h1A
`define PMUSQ_THR_MAX_CODE  3'h5

`define PMUSQ_EV_RST_REL    0
`define PMUSQ_EV_BATT_OK    1
`define PMUSQ_EV_VDD_OK     2
`define PMUSQ_EV_ON_BACKUP  3
`define PMUSQ_EV_W          4

`define PMUSQ_RESP_OKAY     2'h0
`define PMUSQ_RESP_SLVERR   2'h2

`define PMUSQ_CLK_MHZ       100
`define PMUSQ_TICK_US       1000
`define PMUSQ_TICK_CYCLES   (`PMUSQ_CLK_MHZ * `PMUSQ_TICK_US)
`define PMUSQ_HOLD_MS       50
`define PMUSQ_VDD_MAX_MS    120
`endif

/* verilog/pmusq_pkg.sv */
`default_nettype none
`include "pmusq_defines.svh"
package pmusq_pkg;
  typedef enum logic [1:0] {RS_OFF, RS_HOLD, RS_RUN} pmusq_rst_e;

  typedef struct packed {
    logic       backup_present;
    logic       keepalive_supply_good;
    logic       reset_in_n;
    logic       high_voltage_rail_request;
    logic       low_voltage_rail_request;
    logic       rails_in_regulation;
    logic [5:0] vin_dv;
  } pmusq_pins_s;

  typedef struct packed {
    logic                      aw_have;
    logic                      w_have;
    logic [`PMUSQ_ADDR_W-1:0]  awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } pmusq_axi_s;

  typedef struct packed {
    pmusq_pins_s           sync1;
    pmusq_pins_s           sync2;
    pmusq_axi_s            axi;
    logic [1:0]            chg_code;
    logic [2:0]            thr_code;
    logic                  chg_off;
    logic [`PMUSQ_EV_W-1:0] irq_stat;
    logic [`PMUSQ_EV_W-1:0] irq_mask;
    pmusq_rst_e            rst_st;
    logic                  keepalive_en;
    logic                  src_main;
    logic                  charger_en;
    logic [9:0]            charge_ua;
    logic                  hv_en;
    logic                  lv_en;
    logic                  bf_n;
    logic                  sf_n;
    logic                  rst_n;
    logic                  irq;
  } pmusq_state_s;

  typedef struct packed {
    logic [31:0] presc;
    logic [15:0] ticks;
    logic        done;
  } pmusq_timer_s;
endpackage
`default_nettype wire

/* verilog/pmusq_hold_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmusq_defines.svh"
module pmusq_hold_timer #(
  parameter int TICK_CYCLES = `PMUSQ_TICK_CYCLES,
  parameter int HOLD_TICKS  = `PMUSQ_HOLD_MS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic restart,
  input  wire logic run,
  output var  logic done
);
  pmusq_pkg::pmusq_timer_s s_q;
  pmusq_pkg::pmusq_timer_s s_d;

  // slow 1 ms timebase, counted only while running; whole ticks make the hold a minimum
  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d = '0;
    end else if (run && !s_q.done) begin
      if (s_q.presc == 32'(TICK_CYCLES - 1)) begin
        s_d.presc = '0;
        s_d.ticks = s_q.ticks + 16'h0001;
        if (s_q.ticks == 16'(HOLD_TICKS - 1)) begin
          s_d.done = 1'b1;
        end
      end else begin
        s_d.presc = s_q.presc + 32'h00000001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

  chk_tick_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.presc < 32'(TICK_CYCLES)) else $error("prescaler past terminal count");
  chk_done_clear: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    restart |=> !s_q.done) else $error("hold done survives restart");
endmodule
`default_nettype wire

/* verilog/pmusq_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pmusq_defines.svh"
module pmusq_sequencer #(
  parameter int TICK_CYCLES = `PMUSQ_TICK_CYCLES,
  parameter int HOLD_MS     = `PMUSQ_HOLD_MS
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     ce,
  input  wire pmusq_pkg::pmusq_pins_s   pmu_pins,
  input  wire logic [`PMUSQ_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`PMUSQ_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output var  logic                     keepalive_regulator_en,
  output var  logic                     keepalive_src_main,
  output var  logic                     backup_charge_en,
  output var  logic [9:0]               backup_charge_ua,
  output var  logic                     high_voltage_rail_en,
  output var  logic                     low_voltage_rail_en,
  output var  logic                     battery_fault_n,
  output var  logic                     supply_fault_n,
  output var  logic                     reset_out_n,
  output var  logic                     irq
);
  pmusq_pkg::pmusq_state_s s_q;
  pmusq_pkg::pmusq_state_s s_d;
  logic                    tmr_restart;
  logic                    tmr_run;
  logic                    tmr_done;

  pmusq_hold_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .HOLD_TICKS  (HOLD_MS)
  ) u_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .restart (tmr_restart),
    .run     (tmr_run),
    .done    (tmr_done)
  );

  // hold restarts whenever the keep-alive rail drops or the reset input is low
  assign tmr_restart = (s_q.rst_st != pmusq_pkg::RS_HOLD) || !s_q.sync2.reset_in_n
                       || !s_q.sync2.keepalive_supply_good;
  assign tmr_run     = (s_q.rst_st == pmusq_pkg::RS_HOLD);

  function automatic logic [31:0] reg_read(input pmusq_pkg::pmusq_state_s s,
                                           input logic [`PMUSQ_ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case ({a[`PMUSQ_ADDR_W-1:2], 2'h0})
      `PMUSQ_ADDR_CTRL: begin
        v[`PMUSQ_CTRL_CHG_RNG] = s.chg_code;
        v[`PMUSQ_CTRL_THR_RNG] = s.thr_code;
        v[`PMUSQ_CTRL_CHGOFF]  = s.chg_off;
      end
      `PMUSQ_ADDR_STATUS: begin
        v[7:0] = {s.keepalive_en, s.lv_en, s.hv_en, s.charger_en,
                  s.src_main, s.sf_n, s.bf_n, s.rst_n};
        v[9:8] = s.rst_st;
      end
      `PMUSQ_ADDR_IRQ_STAT: v[`PMUSQ_EV_W-1:0] = s.irq_stat;
      `PMUSQ_ADDR_IRQ_MASK: v[`PMUSQ_EV_W-1:0] = s.irq_mask;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic addr_mapped(input logic [`PMUSQ_ADDR_W-1:0] a);
    logic [`PMUSQ_ADDR_W-1:0] w;
    w = {a[`PMUSQ_ADDR_W-1:2], 2'h0};
    return (w == `PMUSQ_ADDR_CTRL) || (w == `PMUSQ_ADDR_STATUS)
           || (w == `PMUSQ_ADDR_IRQ_STAT) || (w == `PMUSQ_ADDR_IRQ_MASK);
  endfunction

  always_comb begin
    logic [`PMUSQ_ADDR_W-1:0] wa;
    logic                     do_wr;
    logic [`PMUSQ_EV_W-1:0]   w1c;
    logic [`PMUSQ_EV_W-1:0]   ev;
    logic [2:0]               thr;
    logic [5:0]               rel_dv;
    logic [5:0]               asr_dv;
    logic [5:0]               vin;
    wa     = '0;
    do_wr  = 1'b0;
    w1c    = '0;
    ev     = '0;
    thr    = '0;
    rel_dv = '0;
    asr_dv = '0;
    vin    = '0;
    s_d    = s_q;

    // pin inputs come from another domain: two flops before use
    s_d.sync1 = pmu_pins;
    s_d.sync2 = s_q.sync1;

    // register bus: address and data held separately, then one write cycle
    if (s_axi_awvalid && s_q.axi.awready) begin
      s_d.axi.aw_have = 1'b1;
      s_d.axi.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.axi.wready) begin
      s_d.axi.w_have = 1'b1;
      s_d.axi.wdata  = s_axi_wdata;
      s_d.axi.wstrb  = s_axi_wstrb;
    end
    wa    = {s_q.axi.awaddr[`PMUSQ_ADDR_W-1:2], 2'h0};
    do_wr = s_q.axi.aw_have && s_q.axi.w_have && !s_q.axi.bvalid;
    if (do_wr) begin
      s_d.axi.aw_have = 1'b0;
      s_d.axi.w_have  = 1'b0;
      s_d.axi.bvalid  = 1'b1;
      s_d.axi.bresp   = addr_mapped(s_q.axi.awaddr) ? `PMUSQ_RESP_OKAY : `PMUSQ_RESP_SLVERR;
      if (s_q.axi.wstrb[0]) begin
        if (wa == `PMUSQ_ADDR_CTRL) begin
          s_d.chg_code = s_q.axi.wdata[`PMUSQ_CTRL_CHG_RNG];
          s_d.thr_code = s_q.axi.wdata[`PMUSQ_CTRL_THR_RNG];
          s_d.chg_off  = s_q.axi.wdata[`PMUSQ_CTRL_CHGOFF];
        end
        if (wa == `PMUSQ_ADDR_IRQ_STAT) begin
          w1c = s_q.axi.wdata[`PMUSQ_EV_W-1:0];
        end
        if (wa == `PMUSQ_ADDR_IRQ_MASK) begin
          s_d.irq_mask = s_q.axi.wdata[`PMUSQ_EV_W-1:0];
        end
      end
    end else if (s_q.axi.bvalid && s_axi_bready) begin
      s_d.axi.bvalid = 1'b0;
    end
    s_d.axi.awready = !s_d.axi.aw_have && !s_d.axi.bvalid;
    s_d.axi.wready  = !s_d.axi.w_have && !s_d.axi.bvalid;

    if (s_axi_arvalid && s_q.axi.arready) begin
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata  = reg_read(s_q, s_axi_araddr);
      s_d.axi.rresp  = addr_mapped(s_axi_araddr) ? `PMUSQ_RESP_OKAY : `PMUSQ_RESP_SLVERR;
    end else if (s_q.axi.rvalid && s_axi_rready) begin
      s_d.axi.rvalid = 1'b0;
    end
    s_d.axi.arready = !s_d.axi.rvalid;

    // battery fault hysteresis; codes above the table clamp to the top pair
    thr    = (s_q.thr_code > `PMUSQ_THR_MAX_CODE) ? `PMUSQ_THR_MAX_CODE : s_q.thr_code;
    rel_dv = `PMUSQ_THR_REL_BASE + {2'h0, thr, 1'b0};
    asr_dv = `PMUSQ_THR_ASR_BASE + {2'h0, thr, 1'b0};
    vin    = s_q.sync2.vin_dv;
    if (vin < rel_dv) begin
      s_d.bf_n = 1'b0;
    end else if (vin >= asr_dv) begin
      s_d.bf_n = 1'b1;
    end

    // supply fault follows the low-voltage request once rails regulate and the battery fault is released
    s_d.sf_n = s_d.bf_n && s_q.sync2.low_voltage_rail_request
               && s_q.sync2.rails_in_regulation;

    // keep-alive source selection and backup charging
    s_d.src_main     = s_d.bf_n;
    s_d.keepalive_en = s_q.sync2.backup_present || s_d.bf_n;
    s_d.charger_en   = s_d.bf_n && s_q.sync2.backup_present && !s_q.chg_off
                       && (s_q.chg_code != 2'h3);
    case (s_q.chg_code)
      2'h0:    s_d.charge_ua = `PMUSQ_CHG_UA0;
      2'h1:    s_d.charge_ua = `PMUSQ_CHG_UA1;
      2'h2:    s_d.charge_ua = `PMUSQ_CHG_UA2;
      default: s_d.charge_ua = `PMUSQ_CHG_UA_OFF;
    endcase

    s_d.hv_en = s_q.sync2.high_voltage_rail_request;
    s_d.lv_en = s_q.sync2.low_voltage_rail_request;

    // reset output sequencing
    case (s_q.rst_st)
      pmusq_pkg::RS_OFF: begin
        s_d.rst_n = 1'b0;
        if (s_q.sync2.backup_present) begin
          s_d.rst_st = pmusq_pkg::RS_HOLD;
        end
      end
      pmusq_pkg::RS_HOLD: begin
        s_d.rst_n = 1'b0;
        if (tmr_done && s_q.sync2.reset_in_n && s_q.sync2.keepalive_supply_good) begin
          s_d.rst_st = pmusq_pkg::RS_RUN;
          s_d.rst_n  = 1'b1;
        end
      end
      pmusq_pkg::RS_RUN: begin
        if (!s_q.sync2.reset_in_n) begin
          s_d.rst_st = pmusq_pkg::RS_HOLD;
          s_d.rst_n  = 1'b0;
        end
      end
      default: begin
        s_d.rst_st = pmusq_pkg::RS_OFF;
        s_d.rst_n  = 1'b0;
      end
    endcase
    if (!s_q.sync2.backup_present && !s_d.bf_n) begin
      s_d.rst_st = pmusq_pkg::RS_OFF;
      s_d.rst_n  = 1'b0;
    end

    // sticky events; a new event wins over a clear in the same cycle
    ev[`PMUSQ_EV_RST_REL]   = s_d.rst_n && !s_q.rst_n;
    ev[`PMUSQ_EV_BATT_OK]   = s_d.bf_n && !s_q.bf_n;
    ev[`PMUSQ_EV_VDD_OK]    = s_d.sf_n && !s_q.sf_n;
    ev[`PMUSQ_EV_ON_BACKUP] = !s_d.src_main && s_q.src_main && s_q.sync2.backup_present;
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.chg_code <= `PMUSQ_CHG_RST;
      s_q.thr_code <= `PMUSQ_THR_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready          = s_q.axi.awready;
  assign s_axi_wready           = s_q.axi.wready;
  assign s_axi_bvalid           = s_q.axi.bvalid;
  assign s_axi_bresp            = s_q.axi.bresp;
  assign s_axi_arready          = s_q.axi.arready;
  assign s_axi_rvalid           = s_q.axi.rvalid;
  assign s_axi_rdata            = s_q.axi.rdata;
  assign s_axi_rresp            = s_q.axi.rresp;
  assign keepalive_regulator_en = s_q.keepalive_en;
  assign keepalive_src_main     = s_q.src_main;
  assign backup_charge_en       = s_q.charger_en;
  assign backup_charge_ua       = s_q.charge_ua;
  assign high_voltage_rail_en   = s_q.hv_en;
  assign low_voltage_rail_en    = s_q.lv_en;
  assign battery_fault_n        = s_q.bf_n;
  assign supply_fault_n         = s_q.sf_n;
  assign reset_out_n            = s_q.rst_n;
  assign irq                    = s_q.irq;

  // cycles spent holding reset with a valid keep-alive rail
  logic [31:0] hold_cyc_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || tmr_restart) begin
      hold_cyc_q <= '0;
    end else if (ce) begin
      hold_cyc_q <= hold_cyc_q + 32'h00000001;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  chk_backup_select: assert property (
    (s_q.sync2.backup_present && !s_q.bf_n) |-> !s_q.src_main)
    else $error("backup battery not selected");
  // judged one cycle on, and only if the battery fault stayed released: a falling
  // input may legally take the source back to backup in that cycle
  chk_main_select: assert property (
    (s_q.sync2.backup_present && !s_q.chg_off && s_q.chg_code != 2'h3) ##1 s_q.bf_n
      |-> (s_q.src_main && s_q.charger_en))
    else $error("main source or charger not engaged");
  chk_chg_decode: assert property (
    (s_q.chg_code == 2'h2) |=> (s_q.charge_ua == `PMUSQ_CHG_UA2))
    else $error("charge current decode wrong");
  chk_ctrl_write: assert property (
    (s_q.axi.aw_have && s_q.axi.w_have && !s_q.axi.bvalid && s_q.axi.wstrb[0]
      && s_q.axi.awaddr == `PMUSQ_ADDR_CTRL)
      |=> (s_q.thr_code == $past(s_q.axi.wdata[4:2]) && s_q.axi.bvalid))
    else $error("control write not applied");
  chk_hv_follow: assert property (
    $rose(s_q.sync2.high_voltage_rail_request) |=> high_voltage_rail_en)
    else $error("high-voltage group not enabled");
  chk_lv_follow: assert property (
    s_q.sync2.low_voltage_rail_request |=> low_voltage_rail_en)
    else $error("low-voltage group not enabled");
  chk_low_vin_faults: assert property (
    (s_q.sync2.vin_dv < `PMUSQ_THR_REL_BASE) |=> (!battery_fault_n && !supply_fault_n))
    else $error("faults released under low input");
  chk_batt_release: assert property (
    (s_q.sync2.vin_dv >= 6'h24) [*2] |-> battery_fault_n)
    else $error("battery fault not released");
  chk_vdd_release: assert property (
    (s_q.sync2.low_voltage_rail_request && s_q.sync2.rails_in_regulation && s_q.bf_n
      && s_q.sync2.vin_dv >= 6'h24) |=> supply_fault_n)
    else $error("supply fault not released");
  chk_por_assert: assert property (
    ($rose(s_q.sync2.backup_present) && s_q.rst_st == pmusq_pkg::RS_OFF)
      |=> (!reset_out_n && keepalive_regulator_en) [*2])
    else $error("power-on reset not asserted");
  chk_hold_min: assert property (
    $rose(reset_out_n) |-> ($past(hold_cyc_q) >= 32'(HOLD_MS * TICK_CYCLES)))
    else $error("reset released too early");
  chk_rsti_assert: assert property (
    (!s_q.sync2.reset_in_n) |=> !reset_out_n)
    else $error("reset input did not assert reset output");
  chk_irq_level: assert property (
    (|(s_q.irq_stat & s_q.irq_mask)) |-> irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

/* tb/pmusq_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmusq_cpu_model #(
  parameter int T_HV  = 100,
  parameter int T_LV  = 1250,
  parameter int T_CHK = 1250
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic reset_out_n,
  input  wire logic battery_fault_n,
  input  wire logic supply_fault_n,
  output var  logic hv_req,
  output var  logic lv_req,
  output var  logic startup_ok
);
  int cnt;

  // a reset from the device restarts the whole start-up walk
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_out_n) begin
      hv_req     <= 1'b0;
      lv_req     <= 1'b0;
      startup_ok <= 1'b0;
      cnt        <= 0;
    end else begin
      cnt <= cnt + 1;
      if (!hv_req && cnt >= T_HV && battery_fault_n) begin
        hv_req <= 1'b1;
        cnt    <= 0;
      end else if (hv_req && !lv_req && cnt >= T_LV) begin
        lv_req <= 1'b1;
        cnt    <= 0;
      end else if (lv_req && cnt == T_CHK) begin
        startup_ok <= supply_fault_n;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int TICK = 10;
  localparam int HOLD = 5;
  localparam int HC   = TICK * HOLD;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic        bp = 1'b0, kg = 1'b0, rin = 1'b1, rails = 1'b1;
  logic [5:0]  vin = 6'h00;
  logic        hv_req, lv_req, ok;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        ka_en, src_main, chg_en, hv_en, lv_en, bf_n, sf_n, rst_n, irq;
  logic [9:0]  chg_ua;
  pmusq_pkg::pmusq_pins_s pins;
  int          miscompares = 0;
  int          num_checks = 0;

  assign pins = {bp, kg, rin, hv_req, lv_req, rails, vin};
  always #5 aclk = ~aclk;

  pmusq_sequencer #(.TICK_CYCLES(TICK), .HOLD_MS(HOLD)) u_pmusq_sequencer (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pmu_pins(pins),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .keepalive_regulator_en(ka_en), .keepalive_src_main(src_main), .backup_charge_en(chg_en),
    .backup_charge_ua(chg_ua), .high_voltage_rail_en(hv_en), .low_voltage_rail_en(lv_en),
    .battery_fault_n(bf_n), .supply_fault_n(sf_n), .reset_out_n(rst_n), .irq(irq));

  pmusq_cpu_model #(.T_HV(10 * TICK), .T_LV(125 * TICK), .T_CHK(125 * TICK)) u_pmusq_cpu_model (
    .aclk(aclk), .aresetn(aresetn), .reset_out_n(rst_n), .battery_fault_n(bf_n),
    .supply_fault_n(sf_n), .hv_req(hv_req), .lv_req(lv_req), .startup_ok(ok));

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic chb(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic lost(input string nm);
    miscompares++;
    $display("[ERR] %s expected handshake seen timeout", nm);
    end_sim();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wt(input string nm, ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (s !== v) lost(nm);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    if (bvalid !== 1'b1) lost("bvalid");
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    if (rvalid !== 1'b1) lost("rvalid");
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  function automatic logic [9:0] ua(input logic [1:0] c);
    case (c)
      2'h0: return 10'h177;
      2'h1: return 10'h1F4;
      2'h2: return 10'h271;
      default: return 10'h000;
    endcase
  endfunction

  // hysteresis: low edge 2.4 V + 0.2 V per code, high edge 0.2 V above it
  function automatic logic bfx(input logic [5:0] v, input logic [2:0] c, input logic p);
    logic [5:0] lo = 6'h18 + {2'h0, (c > 3'h5) ? 3'h5 : c, 1'b0};
    if (v < lo) return 1'b0;
    if (v >= lo + 6'h02) return 1'b1;
    return p;
  endfunction

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    cyc(100000);
    lost("watchdog");
  end

  initial begin
    int n, k;
    logic e;
    logic [5:0] v;
    logic [31:0] r;
    logic [5:0] edge_v [6] = '{6'h17, 6'h18, 6'h1A, 6'h19, 6'h18, 6'h17};
    r = 32'h000161EF;
    cyc(20);
    aresetn <= 1'b1;
    cyc(2);
    rd(8'h00, 32'h00000009, 2'h0);
    rd(8'h0C, 32'h00000000, 2'h0);
    rd(8'h10, 32'h00000000, 2'h2);
    wr(8'h10, 32'hFFFFFFFF, 2'h2);
    wr(8'h0C, 32'h0000000F, 2'h0);
    bp <= 1'b1;
    kg <= 1'b1;
    wt("keepalive_en", ka_en, 1'b1, 10, n);
    cyc(2);
    chb("src_main", src_main, 1'b0);
    chb("charge_en", chg_en, 1'b0);
    chb("batt_fault", bf_n, 1'b0);
    chb("supply_fault", sf_n, 1'b0);
    chb("reset_out", rst_n, 1'b0);
    wt("reset_out", rst_n, 1'b1, 200, k);
    chb("hold_min", (k + n + 2) >= HC, 1'b1);
    chb("hold_max", (k + n + 2) <= HC + 12, 1'b1);
    vin <= 6'h23;
    wt("batt_fault", bf_n, 1'b1, 10, n);
    cyc(3);
    chb("src_main", src_main, 1'b1);
    chb("charge_en", chg_en, 1'b1);
    chk("charge_ua", {22'h0, chg_ua}, {22'h0, ua(2'h1)});
    chb("irq", irq, 1'b1);
    wt("hv_req", hv_req, 1'b1, 3000, n);
    cyc(4);
    chb("hv_en", hv_en, 1'b1);
    chb("lv_en", lv_en, 1'b0);
    chb("supply_fault", sf_n, 1'b0);
    wt("lv_req", lv_req, 1'b1, 3000, n);
    wt("supply_fault", sf_n, 1'b1, 5, n);
    chb("lv_en", lv_en, 1'b1);
    wt("startup_ok", ok, 1'b1, 1400, n);
    // everything up: all status flags set, reset state machine in run
    rd(8'h04, 32'h000002FF, 2'h0);
    wr(8'h08, 32'h0000000F, 2'h0);
    rd(8'h08, 32'h00000000, 2'h0);
    wr(8'h0C, 32'h00000000, 2'h0);
    // enable low freezes the synchronisers too, so the rail drop waits for it
    ce    <= 1'b0;
    rails <= 1'b0;
    cyc(5);
    chb("ce_freeze", sf_n, 1'b1);
    ce <= 1'b1;
    cyc(5);
    chb("supply_fault", sf_n, 1'b0);
    rails <= 1'b1;
    cyc(5);
    chb("supply_fault", sf_n, 1'b1);
    chb("irq", irq, 1'b0);
    rd(8'h08, 32'h00000004, 2'h0);
    wr(8'h0C, 32'h00000004, 2'h0);
    cyc(2);
    chb("irq", irq, 1'b1);
    wr(8'h08, 32'h00000004, 2'h0);
    cyc(2);
    chb("irq", irq, 1'b0);
    for (k = 0; k < 5; k++) begin
      // the last pass sets the charger-off bit with a valid code
      wr(8'h00, (k == 4) ? 32'h00000029 : 32'h00000008 | k, 2'h0);
      cyc(4);
      chb("charge_en", chg_en, k < 3);
      if (k < 4) chk("charge_ua", {22'h0, chg_ua}, {22'h0, ua(k[1:0])});
    end
    e = 1'b1;
    v = 6'h23;
    for (int c = 0; c < 9; c++) begin
      wr(8'h00, {27'h0, c[2:0], 2'h1}, 2'h0);
      e = bfx(v, c[2:0], e);
      for (k = 0; k < 6; k++) begin
        r = nx(r);
        v = (c == 8) ? edge_v[k] : 6'(r % 26) + 6'h14;
        vin <= v;
        cyc(6);
        e = bfx(v, (c == 8) ? 3'h0 : c[2:0], e);
        chb("batt_fault", bf_n, e);
        chb("fault_order", sf_n & ~bf_n, 1'b0);
      end
    end
    // last pass releases then re-asserts the fault: released, supply ok, on backup
    rd(8'h08, 32'h0000000E, 2'h0);
    vin <= 6'h23;
    rin <= 1'b0;
    wt("reset_out", rst_n, 1'b0, 6, n);
    cyc(3);
    rin <= 1'b1;
    cyc(HC - 10);
    chb("reset_out", rst_n, 1'b0);
    wt("reset_out", rst_n, 1'b1, 100, n);
    chb("hold_min", (HC - 10 + n) >= HC, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
